// >>> cbc_charger_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Fast-charge current code is read/write in bits 7:4 of register 08h.
// [R2] Current code 0 is 100 mA, then 300 mA plus 50 mA per step; default 0100.
// [R3] Termination voltage code bits 2:0 of 08h, 4.10 V plus 20 mV/step, default 101.
// [R4] Register 09h bit 0 shows input power good, bit 1 shows charging.
// [R5] Register 09h bit 3 shows timeout fault, bit 4 shows battery removed.
// [R6] Bit 3 of 08h, bits 2 and 5 of 09h, 0Ah, bits 7:2 of 0Bh read-only.
// [R7] Suspend bit at 0Bh bit 0; one disables charging, zero allows it.
// [R8] Register 0Bh bit 1 reads zero after a charging error, one when healthy.
// [R9] Charger runs only with input above battery, above 4.0 V, enable pin low.
// [R10] Enable pin high keeps the charger off whatever the voltages.
// [R11] The controller drives the enable pin low to permit, high to stop charging.
// [R12] Without a battery the node is held at the termination voltage.
// [R13] Normal cycle regulates the selected current until termination voltage.
// [R14] At termination voltage switch to constant voltage, current falls.
// [R15] A valid input starts a fresh charging cycle automatically.
// [R16] Timeout code in 09h bits 7:6 picks precondition and total limits.
// [R17] Clearing suspend resets the timer and restarts in precondition.
// [R18] Timeout fault leaves only through the suspend state.
// [R19] Writes to read-only bits and the reserved register are ignored.
// [R20] Status bits follow live conditions on every read.
module cbc_charger_regs
  import cbc_pkg::*;
#(
  parameter longint CLK_HZ = cbc_pkg::CBC_CLK_HZ
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        charge_enable_n_pin,
  input  wire logic        input_above_battery,
  input  wire logic        input_above_uvlo,
  input  wire logic        battery_present,
  input  wire logic        vbat_above_precond,
  input  wire logic        vbat_at_term,
  input  wire logic        eoc_current_low,
  input  wire logic        vbat_below_restart,
  output logic             charger_on,
  output logic             cv_mode,
  output logic      [9:0]  current_target_ma,
  output logic      [12:0] term_voltage_mv,
  output cbc_pkg::cbc_state_e charge_state
);
  import cbc_pkg::*;

  initial begin
    if (CLK_HZ < 1) $error("cbc_charger_regs: CLK_HZ must be positive");
  end

  // ==========================================================
  // Decode functions
  function automatic logic [9:0] cbc_current_ma(input logic [3:0] code);
    if (code == 4'h0) return CBC_I_CODE0_MA;
    // Base is the value one step below code 1, so code 1 lands on 300 mA
    return 10'(CBC_I_BASE_MA + 10'(CBC_I_STEP_MA * 10'(code)));
  endfunction

  function automatic logic [12:0] cbc_voltage_mv(input logic [2:0] code);
    return 13'(CBC_V_BASE_MV + 13'(CBC_V_STEP_MV * 13'(code)));
  endfunction

  // ==========================================================
  // Pin synchronisation
  logic [7:0] sync_q;
  logic       en_n_s, in_bat_s, in_uvlo_s, bat_s, pre_s, term_s, eoc_s, restart_s;

  cbc_sync #(
    .WIDTH (8)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({charge_enable_n_pin, input_above_battery, input_above_uvlo, battery_present,
                vbat_above_precond, vbat_at_term, eoc_current_low, vbat_below_restart}),
    .sync_out (sync_q)
  );

  // Enable pin comes out of reset as low-sync; the enable path also needs input good
  assign {en_n_s, in_bat_s, in_uvlo_s, bat_s, pre_s, term_s, eoc_s, restart_s} = sync_q;

  // ==========================================================
  // Control registers
  logic [3:0] fast_current_sel_reg;
  logic [2:0] term_voltage_sel_reg;
  logic [1:0] timeout_option_sel_reg;
  logic       suspend_charge_bit_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fast_current_sel_reg   <= CBC_FAST_CURRENT_SEL_RST;
      term_voltage_sel_reg   <= CBC_TERM_VOLTAGE_SEL_RST;
      timeout_option_sel_reg <= CBC_TIMO_RST;
      suspend_charge_bit_reg <= 1'b0;
    end else if (reg_wr) begin
      // Only writable fields take data; everything else drops the write [R19]
      case (reg_addr)
        CBC_ADDR_SETTING: begin
          fast_current_sel_reg <= reg_wdata[CBC_FAST_CURRENT_SEL_LSB +: 4]; // [R1]
          term_voltage_sel_reg <= reg_wdata[2:0]; // [R3]
        end
        CBC_ADDR_STATUS:  timeout_option_sel_reg <= reg_wdata[CBC_TIMO_LSB +: 2]; // [R16]
        CBC_ADDR_SUSPEND: suspend_charge_bit_reg <= reg_wdata[CBC_SUSP_BIT]; // [R7]
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Qualification of the input supply
  logic input_power_good;
  logic charger_enable;

  assign input_power_good = in_bat_s && in_uvlo_s; // [R9]
  // Enable pin high overrides everything else [R10] [R11]
  assign charger_enable   = input_power_good && !en_n_s && !suspend_charge_bit_reg; // [R9] [R7]

  // ==========================================================
  // Safety timer
  logic       minute_tick;
  logic       timer_restart;
  logic [7:0] minutes_reg;
  logic [7:0] pre_limit;
  logic [7:0] tot_limit;
  logic       pre_expired;
  logic       tot_expired;
  cbc_state_e state_reg;
  cbc_state_e state_next;

  cbc_tick #(
    .CYCLES_PER_SEC (CLK_HZ),
    .SEC_PER_MIN    (CBC_SEC_PER_MIN)
  ) u_tick (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .restart     (timer_restart),
    .minute_tick (minute_tick)
  );

  always_comb begin
    case (timeout_option_sel_reg) // [R16]
      2'h0:    begin pre_limit = CBC_PRE_60_MIN; tot_limit = CBC_TOT_180_MIN; end
      2'h2:    begin pre_limit = CBC_PRE_30_MIN; tot_limit = CBC_TOT_90_MIN;  end
      2'h3:    begin pre_limit = CBC_PRE_45_MIN; tot_limit = CBC_TOT_132_MIN; end
      default: begin pre_limit = CBC_PRE_60_MIN; tot_limit = CBC_TOT_180_MIN; end
    endcase
  end

  // Option 01 switches both limits off
  assign pre_expired = (timeout_option_sel_reg != CBC_TIMO_OFF) && (minutes_reg >= pre_limit); // [R16]
  assign tot_expired = (timeout_option_sel_reg != CBC_TIMO_OFF) && (minutes_reg >= tot_limit); // [R16]

  // Timer restarts whenever a cycle begins afresh
  assign timer_restart = (state_next == CBC_ST_PRECOND && state_reg != CBC_ST_PRECOND) ||
                         (state_next == CBC_ST_FAST && state_reg == CBC_ST_SLEEP); // [R17]

  always_ff @(posedge ref_clk) begin
    if (!rst_n || timer_restart) begin
      minutes_reg <= '0;
    end else if (minute_tick && minutes_reg != 8'hff) begin
      // Saturates so a long sleep cannot wrap into a false pass
      minutes_reg <= minutes_reg + 8'd1;
    end
  end

  // ==========================================================
  // Charge state machine
  always_comb begin
    state_next = state_reg;
    if (!charger_enable) begin
      state_next = CBC_ST_SUSPEND; // [R10] [R18]
    end else begin
      case (state_reg)
        CBC_ST_SUSPEND: state_next = bat_s ? CBC_ST_PRECOND : CBC_ST_NOBAT; // [R15] [R17]
        CBC_ST_NOBAT:   if (bat_s) state_next = CBC_ST_PRECOND; // [R12]
        CBC_ST_PRECOND: begin
          if (!bat_s)           state_next = CBC_ST_NOBAT;
          else if (pre_expired) state_next = CBC_ST_FAULT;
          else if (pre_s)       state_next = CBC_ST_FAST;
        end
        CBC_ST_FAST: begin
          if (!bat_s)           state_next = CBC_ST_NOBAT;
          else if (tot_expired) state_next = CBC_ST_FAULT;
          else if (term_s)      state_next = CBC_ST_TOPOFF; // [R13] [R14]
        end
        CBC_ST_TOPOFF: begin
          if (!bat_s)           state_next = CBC_ST_NOBAT;
          else if (tot_expired) state_next = CBC_ST_FAULT;
          else if (eoc_s)       state_next = CBC_ST_SLEEP;
        end
        CBC_ST_SLEEP: begin
          if (!bat_s)           state_next = CBC_ST_NOBAT;
          else if (restart_s)   state_next = CBC_ST_FAST;
        end
        // No direct way back to charging; removal leads through suspend
        CBC_ST_FAULT:   if (!bat_s) state_next = CBC_ST_SUSPEND; // [R18]
        default:        state_next = CBC_ST_SUSPEND;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= CBC_ST_SUSPEND;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Regulation targets for the analogue loop
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      charger_on        <= 1'b0;
      cv_mode           <= 1'b0;
      current_target_ma <= '0;
      term_voltage_mv   <= cbc_voltage_mv(CBC_TERM_VOLTAGE_SEL_RST);
    end else begin
      term_voltage_mv <= cbc_voltage_mv(term_voltage_sel_reg); // [R3]
      charger_on      <= state_reg inside {CBC_ST_PRECOND, CBC_ST_FAST, CBC_ST_TOPOFF, CBC_ST_NOBAT};
      cv_mode         <= state_reg inside {CBC_ST_TOPOFF, CBC_ST_NOBAT}; // [R14] [R12]
      case (state_reg)
        CBC_ST_PRECOND: current_target_ma <= cbc_current_ma(fast_current_sel_reg) / CBC_PRECOND_DIV;
        CBC_ST_FAST,
        CBC_ST_TOPOFF:  current_target_ma <= cbc_current_ma(fast_current_sel_reg); // [R2] [R13]
        CBC_ST_NOBAT:   current_target_ma <= CBC_I_NOBAT_MA;
        default:        current_target_ma <= '0;
      endcase
    end
  end

  assign charge_state = state_reg;

  // ==========================================================
  // Status and read-back
  logic charging_active;
  logic timeout_fault_flag;
  logic battery_removed_flag;
  logic charge_health_ok;

  assign charging_active      = state_reg inside {CBC_ST_PRECOND, CBC_ST_FAST, CBC_ST_TOPOFF}; // [R20]
  assign timeout_fault_flag   = (state_reg == CBC_ST_FAULT); // [R5]
  assign battery_removed_flag = input_power_good && !bat_s; // [R5] [R20]
  assign charge_health_ok     = !timeout_fault_flag; // [R8]

  // Read-only and reserved positions read as zero [R6]
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      case (reg_addr)
        CBC_ADDR_SETTING: reg_rdata <= {fast_current_sel_reg, 1'b0, term_voltage_sel_reg}; // [R1] [R3]
        CBC_ADDR_STATUS: begin
          reg_rdata[CBC_TIMO_LSB +: 2] <= timeout_option_sel_reg;
          reg_rdata[CBC_BFLT_BIT]      <= battery_removed_flag; // [R5]
          reg_rdata[CBC_TFLT_BIT]      <= timeout_fault_flag; // [R5]
          reg_rdata[CBC_ACTIVE_BIT]    <= charging_active; // [R4]
          reg_rdata[CBC_PGOOD_BIT]     <= input_power_good; // [R4]
        end
        CBC_ADDR_SUSPEND: begin
          reg_rdata[CBC_HEALTH_BIT] <= charge_health_ok; // [R8]
          reg_rdata[CBC_SUSP_BIT]   <= suspend_charge_bit_reg; // [R7]
        end
        default: reg_rdata <= '0;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_fast_current_sel_write;
    reg_wr && reg_addr == CBC_ADDR_SETTING |=> fast_current_sel_reg == $past(reg_wdata[7:4]);
  endproperty
  a_fast_current_sel_write: assert property (p_fast_current_sel_write) else $error("Current field not written"); // [R1]

  property p_current_fast;
    state_reg == CBC_ST_FAST |=>
      current_target_ma == cbc_current_ma($past(fast_current_sel_reg));
  endproperty
  a_current_fast: assert property (p_current_fast) else $error("Fast current target wrong"); // [R2]

  property p_term_voltage_sel_read;
    reg_addr == CBC_ADDR_SETTING && !reg_wr |=> reg_rdata[2:0] == $past(term_voltage_sel_reg) && !reg_rdata[3];
  endproperty
  a_term_voltage_sel_read: assert property (p_term_voltage_sel_read) else $error("Voltage field read wrong"); // [R3]

  property p_pin_off;
    en_n_s |=> state_reg == CBC_ST_SUSPEND ##1 !charger_on;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("Charger on with enable pin high"); // [R10]

  property p_rsvd_read;
    reg_addr == CBC_ADDR_RSVD |=> reg_rdata == 8'h00;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("Reserved register not zero"); // [R6]

  property p_fault_exit;
    state_reg == CBC_ST_FAULT |=> state_reg inside {CBC_ST_FAULT, CBC_ST_SUSPEND};
  endproperty
  a_fault_exit: assert property (p_fault_exit) else $error("Fault left without suspend"); // [R18]

  property p_resume_precond;
    state_reg == CBC_ST_SUSPEND && charger_enable && bat_s |=> state_reg == CBC_ST_PRECOND && minutes_reg == 8'h00;
  endproperty
  a_resume_precond: assert property (p_resume_precond) else $error("Resume not in precondition"); // [R17]

  property p_status_live;
    reg_addr == CBC_ADDR_STATUS |=> reg_rdata[CBC_PGOOD_BIT] == $past(input_power_good) &&
      reg_rdata[CBC_ACTIVE_BIT] == $past(charging_active) && reg_rdata[CBC_TFLT_BIT] == $past(timeout_fault_flag);
  endproperty
  a_status_live: assert property (p_status_live) else $error("Status read stale"); // [R20]

  property p_nobat_cv;
    state_reg == CBC_ST_NOBAT |=> cv_mode && charger_on && current_target_ma == CBC_I_NOBAT_MA;
  endproperty
  a_nobat_cv: assert property (p_nobat_cv) else $error("No-battery regulation wrong"); // [R12]

  property p_timer_off;
    timeout_option_sel_reg == CBC_TIMO_OFF && state_reg == CBC_ST_PRECOND |=> state_reg != CBC_ST_FAULT;
  endproperty
  a_timer_off: assert property (p_timer_off) else $error("Fault with timer disabled"); // [R16]
endmodule // cbc_charger_regs

// >>> cbc_pkg.sv
package cbc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] CBC_ADDR_SETTING = 8'h08;
  localparam logic [7:0] CBC_ADDR_STATUS  = 8'h09;
  localparam logic [7:0] CBC_ADDR_RSVD    = 8'h0a;
  localparam logic [7:0] CBC_ADDR_SUSPEND = 8'h0b;

  // ==========================================================
  // Field positions
  localparam int CBC_FAST_CURRENT_SEL_LSB   = 4;
  localparam int CBC_TIMO_LSB   = 6;
  localparam int CBC_PGOOD_BIT  = 0;
  localparam int CBC_ACTIVE_BIT = 1;
  localparam int CBC_TFLT_BIT   = 3;
  localparam int CBC_BFLT_BIT   = 4;
  localparam int CBC_SUSP_BIT   = 0;
  localparam int CBC_HEALTH_BIT = 1;

  // ==========================================================
  // Reset values
  localparam logic [3:0] CBC_FAST_CURRENT_SEL_RST = 4'h4;
  localparam logic [2:0] CBC_TERM_VOLTAGE_SEL_RST = 3'h5;
  localparam logic [1:0] CBC_TIMO_RST = 2'h0;

  // ==========================================================
  // Decode constants
  localparam logic [9:0]  CBC_I_CODE0_MA  = 10'h064;
  localparam logic [9:0]  CBC_I_BASE_MA   = 10'h0fa;
  localparam logic [9:0]  CBC_I_STEP_MA   = 10'h032;
  localparam logic [9:0]  CBC_I_NOBAT_MA  = 10'h3e8;
  localparam logic [9:0]  CBC_PRECOND_DIV = 10'h00a;
  localparam logic [12:0] CBC_V_BASE_MV   = 13'h1004;
  localparam logic [12:0] CBC_V_STEP_MV   = 13'h0014;
  localparam logic [1:0]  CBC_TIMO_OFF    = 2'h1;

  // ==========================================================
  // Timing: times in minutes, clock rate in Hz
  localparam longint CBC_CLK_HZ      = 100_000_000;
  localparam int     CBC_SEC_PER_MIN = 60;
  localparam logic [7:0] CBC_PRE_60_MIN = 8'd60;
  localparam logic [7:0] CBC_PRE_30_MIN = 8'd30;
  localparam logic [7:0] CBC_PRE_45_MIN = 8'd45;
  localparam logic [7:0] CBC_TOT_180_MIN = 8'd180;
  localparam logic [7:0] CBC_TOT_90_MIN  = 8'd90;
  localparam logic [7:0] CBC_TOT_132_MIN = 8'd132;

  typedef enum logic [2:0] {
    CBC_ST_SUSPEND = 3'b000,
    CBC_ST_PRECOND = 3'b001,
    CBC_ST_FAST    = 3'b010,
    CBC_ST_TOPOFF  = 3'b011,
    CBC_ST_SLEEP   = 3'b100,
    CBC_ST_FAULT   = 3'b101,
    CBC_ST_NOBAT   = 3'b110
  } cbc_state_e;
endpackage

// >>> cbc_sync.sv
`timescale 1ns/1ps
// ==========================================================
// Two-stage synchroniser bank
module cbc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  initial begin
    if (WIDTH < 1) $error("cbc_sync: WIDTH must be positive");
  end

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // cbc_sync

// >>> cbc_tick.sv
`timescale 1ns/1ps
// ==========================================================
// One-minute tick from the reference clock
module cbc_tick #(
  parameter longint CYCLES_PER_SEC = 100_000_000,
  parameter int     SEC_PER_MIN    = 60
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic restart,
  output logic      minute_tick
);
  logic [31:0] cyc_reg;
  logic [7:0]  sec_reg;

  initial begin
    if (CYCLES_PER_SEC < 1 || CYCLES_PER_SEC > 64'hffff_ffff) $error("cbc_tick: bad CYCLES_PER_SEC");
    if (SEC_PER_MIN < 1 || SEC_PER_MIN > 255) $error("cbc_tick: bad SEC_PER_MIN");
  end

  // Restart aligns the first tick to a full minute after timer reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n || restart) begin
      cyc_reg     <= '0;
      sec_reg     <= '0;
      minute_tick <= 1'b0;
    end else begin
      minute_tick <= 1'b0;
      if (cyc_reg == 32'(CYCLES_PER_SEC - 1)) begin
        cyc_reg <= '0;
        if (sec_reg == 8'(SEC_PER_MIN - 1)) begin
          sec_reg     <= '0;
          minute_tick <= 1'b1;
        end else begin
          sec_reg <= sec_reg + 8'd1;
        end
      end else begin
        cyc_reg <= cyc_reg + 32'd1;
      end
    end
  end
endmodule // cbc_tick

// >>> cbc_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host side: byte register accesses and the enable pin
module cbc_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            charge_enable_n_pin
);
  initial begin
    reg_addr            = 8'h00;
    reg_wr              = 1'b0;
    reg_wdata           = 8'h00;
    charge_enable_n_pin = 1'b1;
  end

  // One byte per write; the strobe covers exactly one sampling edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // Data is taken one edge after the address is driven
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    @(posedge ref_clk);
    #1 d = reg_rdata;
  endtask

  // Low permits charging, high forces the charger off
  task automatic set_enable(input logic on);
    @(posedge ref_clk);
    charge_enable_n_pin <= ~on;
  endtask
endmodule // cbc_host_model

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cbc_pkg::*;
  // ==========================================================
  // Signals
  localparam longint SIM_HZ = 10; // One minute becomes 600 cycles
  logic        ref_clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        enable_n;
  logic        sup_gt_batt;
  logic        sup_uvlo_ok;
  logic        batt_in;
  logic        v_pre;
  logic        v_term;
  logic        eoc_lo;
  logic        v_rst;
  logic        charger_on;
  logic        cv_mode;
  logic [9:0]  current_target_ma;
  logic [12:0] term_voltage_mv;
  cbc_state_e  charge_state;
  logic [31:0] lfsr;
  logic [7:0]  rd;
  logic [7:0]  d;
  int          n_errors;
  int          checks_done;

  cbc_charger_regs #(.CLK_HZ(SIM_HZ)) i_cbc_charger_regs (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .charge_enable_n_pin(enable_n),
    .input_above_battery(sup_gt_batt), .input_above_uvlo(sup_uvlo_ok), .battery_present(batt_in),
    .vbat_above_precond(v_pre), .vbat_at_term(v_term), .eoc_current_low(eoc_lo),
    .vbat_below_restart(v_rst), .charger_on(charger_on), .cv_mode(cv_mode),
    .current_target_ma(current_target_ma), .term_voltage_mv(term_voltage_mv),
    .charge_state(charge_state));

  cbc_host_model i_cbc_host_model (
    .ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .charge_enable_n_pin(enable_n));

  // ==========================================================
  // Expectations and helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [12:0] exp_ma(input logic [3:0] c);
    return (c == 4'h0) ? 13'h0064 : 13'h00fa + 13'h0032 * {9'h000, c};
  endfunction
  function automatic logic [12:0] exp_mv(input logic [2:0] c);
    return 13'h1004 + 13'h0014 * {10'h000, c};
  endfunction
  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    i_cbc_host_model.rd_reg(a, rd);
    chk({5'h00, rd}, {5'h00, exp}, what);
  endtask
  task automatic chk_st(input cbc_state_e s, input string what);
    chk({10'h000, charge_state}, {10'h000, s}, what);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic set_pins(input logic [6:0] v);
    @(posedge ref_clk);
    {sup_gt_batt, sup_uvlo_ok, batt_in, v_pre, v_term, eoc_lo, v_rst} <= v;
    cyc(8);
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Run is about 40k cycles; the limit is about twice that
  initial begin
    #800_000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    finish_test;
  end

  // ==========================================================
  // Scenarios
  initial begin
    n_errors    = 0;
    checks_done = 0;
    lfsr        = 32'h0000_51d7;
    rst_n       = 1'b0;
    {sup_gt_batt, sup_uvlo_ok, batt_in, v_pre, v_term, eoc_lo, v_rst} = 7'h00;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(CBC_ADDR_SETTING, 8'h45, "setting default");
    chk(term_voltage_mv, 13'h1068, "default volts");
    rd_chk(CBC_ADDR_RSVD, 8'h00, "reserved default");
    rd_chk(8'h0c, 8'h00, "unmapped read");
    rd_chk(CBC_ADDR_SUSPEND, 8'h02, "suspend default");
    // Valid input, enable low, healthy cell: charging starts by itself
    set_pins(7'b111_1000);
    i_cbc_host_model.set_enable(1'b1);
    cyc(8);
    chk_st(CBC_ST_FAST, "auto start");
    rd_chk(CBC_ADDR_STATUS, 8'h03, "status charging");
    // Random settings, with both extreme codes first
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : lfsr[7:0];
      i_cbc_host_model.wr_reg(CBC_ADDR_SETTING, d);
      cyc(4);
      rd_chk(CBC_ADDR_SETTING, d & 8'hf7, "setting readback");
      chk({3'h0, current_target_ma}, exp_ma(d[7:4]), "fast current");
      chk(term_voltage_mv, exp_mv(d[2:0]), "term volts");
    end
    i_cbc_host_model.wr_reg(CBC_ADDR_RSVD, lfsr[15:8]);
    rd_chk(CBC_ADDR_RSVD, 8'h00, "reserved write");
    i_cbc_host_model.wr_reg(CBC_ADDR_STATUS, 8'h3f);
    rd_chk(CBC_ADDR_STATUS, 8'h03, "status write");
    i_cbc_host_model.wr_reg(CBC_ADDR_SUSPEND, 8'hfe);
    rd_chk(CBC_ADDR_SUSPEND, 8'h02, "health write");
    // Termination reached, end of charge, restart
    set_pins(7'b111_1100);
    chk_st(CBC_ST_TOPOFF, "top-off");
    chk({12'h000, cv_mode}, 13'h0001, "cv mode");
    set_pins(7'b111_1110);
    chk_st(CBC_ST_SLEEP, "sleep");
    set_pins(7'b111_1001);
    chk_st(CBC_ST_FAST, "restart");
    set_pins(7'b111_1000);
    // Enable pin and supply conditions
    i_cbc_host_model.set_enable(1'b0);
    cyc(8);
    chk({12'h000, charger_on}, 13'h0000, "pin off");
    rd_chk(CBC_ADDR_STATUS, 8'h01, "status pin off");
    i_cbc_host_model.set_enable(1'b1);
    cyc(8);
    chk({12'h000, charger_on}, 13'h0001, "pin on");
    set_pins(7'b101_1000);
    chk({12'h000, charger_on}, 13'h0000, "below uvlo");
    rd_chk(CBC_ADDR_STATUS, 8'h00, "status no input");
    set_pins(7'b011_1000);
    chk({12'h000, charger_on}, 13'h0000, "below battery");
    // No cell: hold the node at the programmed voltage
    set_pins(7'b110_1000);
    chk_st(CBC_ST_NOBAT, "no cell");
    chk({12'h000, cv_mode}, 13'h0001, "no cell cv");
    chk({3'h0, current_target_ma}, 13'h03e8, "no cell current");
    i_cbc_host_model.rd_reg(CBC_ADDR_STATUS, rd);
    chk({5'h00, rd & 8'hfd}, 13'h0011, "status removed");
    set_pins(7'b111_0000);
    chk_st(CBC_ST_PRECOND, "cell back");
    // Suspend and release
    i_cbc_host_model.wr_reg(CBC_ADDR_SUSPEND, 8'h01);
    cyc(6);
    chk_st(CBC_ST_SUSPEND, "suspended");
    chk({12'h000, charger_on}, 13'h0000, "suspend off");
    rd_chk(CBC_ADDR_SUSPEND, 8'h03, "suspend readback");
    i_cbc_host_model.wr_reg(CBC_ADDR_SETTING, 8'ha5);
    i_cbc_host_model.wr_reg(CBC_ADDR_SUSPEND, 8'h00);
    cyc(6);
    chk_st(CBC_ST_PRECOND, "release");
    chk({3'h0, current_target_ma}, 13'h004b, "precond current");
    // Timers off: a long precondition never faults
    i_cbc_host_model.wr_reg(CBC_ADDR_STATUS, 8'h40);
    cyc(20000);
    chk_st(CBC_ST_PRECOND, "timer off");
    // Thirty minutes of precondition, timer restarted by a suspend
    // Suspend first so the shorter limit cannot trip on the old count
    i_cbc_host_model.wr_reg(CBC_ADDR_SUSPEND, 8'h01);
    i_cbc_host_model.wr_reg(CBC_ADDR_STATUS, 8'h80);
    i_cbc_host_model.wr_reg(CBC_ADDR_SUSPEND, 8'h00);
    cyc(30 * 600 - 1000);
    chk_st(CBC_ST_PRECOND, "before limit");
    for (int k = 0; k < 2000 && charge_state !== CBC_ST_FAULT; k++) @(posedge ref_clk);
    #1;
    chk_st(CBC_ST_FAULT, "timeout");
    rd_chk(CBC_ADDR_STATUS, 8'h89, "status fault");
    rd_chk(CBC_ADDR_SUSPEND, 8'h00, "health error");
    // A recovered cell does not leave the fault; only suspend does
    set_pins(7'b111_1000);
    chk_st(CBC_ST_FAULT, "fault held");
    i_cbc_host_model.wr_reg(CBC_ADDR_SUSPEND, 8'h01);
    cyc(6);
    chk_st(CBC_ST_SUSPEND, "fault exit");
    i_cbc_host_model.wr_reg(CBC_ADDR_SUSPEND, 8'h00);
    cyc(8);
    chk({12'h000, charger_on}, 13'h0001, "resume");
    finish_test;
  end
endmodule // tb_top
